// ===== ebm_pkg.sv
package ebm_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int FC_W   = 3;

    // Clock rate
    localparam int CLK_MHZ = 50;

    // Transfer size encodings on the size pins
    localparam logic [1:0] SIZ_LONG = 2'h0;
    localparam logic [1:0] SIZ_BYTE = 2'h1;
    localparam logic [1:0] SIZ_WORD = 2'h2;
    localparam logic [1:0] SIZ_TRI  = 2'h3;

    // Acknowledge codes, active low pair {high, low}
    localparam logic [1:0] ACK_NONE  = 2'h3;
    localparam logic [1:0] ACK_PORT8 = 2'h2;
    localparam logic [1:0] ACK_PORT16 = 2'h1;

    // Fast-termination cycle length in clocks
    localparam int FAST_CLKS = 2;

    typedef enum logic [2:0] {
        EBM_IDLE,
        EBM_S0,
        EBM_S2,
        EBM_WAIT,
        EBM_S4,
        EBM_FAST
    } ebm_state_e;

    typedef enum logic [1:0] {
        EBM_OK,
        EBM_BUS_ERROR_IN,
        EBM_RETRY
    } ebm_status_e;
endpackage

// ===== ebm_sync.sv
`timescale 1ns/100ps
// Two-stage falling-edge synchroniser for asynchronous bus inputs
module ebm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta   <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// ===== ebm_master.sv
`timescale 1ns/100ps
module ebm_master
    import ebm_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input  wire logic          core_clk_i,
    input  wire logic          rst_b_i,
    // Core request side
    input  wire logic          req_valid_i,
    output logic               req_ready_o,
    input  wire logic          req_write_i,
    input  wire logic [AW-1:0] req_addr_i,
    input  wire logic [1:0]    req_size_i,
    input  wire logic [FC_W-1:0] req_fc_i,
    input  wire logic [DW-1:0] req_wdata_i,
    input  wire logic          fast_term_enable_i,
    input  wire logic [1:0]    ack_delay_field_i,
    output logic               done_o,
    output logic [DW-1:0]      rdata_o,
    output logic               port8_o,
    output ebm_status_e        status_o,
    // External bus
    output logic [AW-1:0]      addr_o,
    output logic [FC_W-1:0]    function_code_o,
    output logic               transfer_size_hi_o,
    output logic               transfer_size_lo_o,
    output logic               read_write_o,
    output logic               addr_strobe_b_o,
    output logic               data_strobe_b_o,
    output logic               upper_byte_write_en_b_o,
    output logic               lower_byte_write_en_b_o,
    input  wire logic [DW-1:0] data_i,
    output logic [DW-1:0]      data_o,
    output logic               data_oe_o,
    input  wire logic          port_ack_high_b_i,
    input  wire logic          port_ack_low_b_i,
    input  wire logic          bus_error_in_b_i,
    input  wire logic          halt_b_i,
    output logic               bus_clock_out_o
);
    ebm_state_e  state;
    ebm_state_e  next_state;
    logic [1:0]  ack_s;
    logic [1:0]  bus_error_in_s;
    logic [1:0]  ack_cap;
    logic        bus_error_in_seen;
    logic        halt_seen;
    logic        rd_phase;
    logic        is_write;
    logic        is_fast;
    logic        as_n;
    logic        ds_n;
    logic        we_n;
    logic [DW-1:0] rd_lat;

    // Two falling-edge stages keep metastability away from the sequencer
    ebm_sync #(.WIDTH(4), .RST_VAL(4'hf)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    ({port_ack_high_b_i, port_ack_low_b_i,
                      bus_error_in_b_i, halt_b_i}),
        .sync_o     ({ack_s, bus_error_in_s})
    );

    function automatic logic [1:0] lane_enables(input logic [1:0] siz,
                                                input logic a0);
        if (siz == SIZ_BYTE)
            lane_enables = a0 ? 2'b01 : 2'b10;
        else
            lane_enables = a0 ? 2'b01 : 2'b11;
    endfunction

    wire       ack_seen   = (ack_s != ACK_NONE);
    wire       bus_error_in_now   = !bus_error_in_s[1];
    wire       halt_now   = !bus_error_in_s[0];
    wire       terminated = ack_seen || bus_error_in_now;
    wire [1:0] lanes      = lane_enables({transfer_size_hi_o,
                                          transfer_size_lo_o}, addr_o[0]);
    wire       accept     = req_valid_i && state == EBM_IDLE;

    assign req_ready_o     = (state == EBM_IDLE);
    assign bus_clock_out_o = core_clk_i;

    // Sequencer steps on the falling edge like the bus it drives; S0/S1
    // and S4/S5 are the two halves of one falling-edge interval.
    always_comb begin
        next_state = state;
        case (state)
            EBM_IDLE: if (req_valid_i) next_state = EBM_S0;
            // fast termination ignores the acknowledge delay setting
            EBM_S0:   next_state = is_fast ? EBM_FAST : EBM_S2;
            EBM_S2:   next_state = terminated ? EBM_S4 : EBM_WAIT;
            EBM_WAIT: if (terminated) next_state = EBM_S4;
            EBM_S4:   next_state = EBM_IDLE;
            EBM_FAST: next_state = EBM_IDLE;
            default:  next_state = EBM_IDLE;
        endcase
    end

    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            state <= EBM_IDLE;
        else
            state <= next_state;
    end

    // Cycle attributes, held from S0 through the end of S5
    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_o             <= '0;
            function_code_o    <= '0;
            transfer_size_hi_o <= 1'b0;
            transfer_size_lo_o <= 1'b0;
            read_write_o       <= 1'b1;
            is_write           <= 1'b0;
            is_fast            <= 1'b0;
            data_o             <= '0;
        end else if (accept) begin
            addr_o             <= req_addr_i;
            function_code_o    <= req_fc_i;
            transfer_size_hi_o <= req_size_i[1];
            transfer_size_lo_o <= req_size_i[0];
            read_write_o       <= !req_write_i;
            is_write           <= req_write_i;
            is_fast            <= fast_term_enable_i;
            data_o             <= req_wdata_i;
        end
    end

    // Strobes change half a clock after S0 begins, hence the rising edge
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            as_n      <= 1'b1;
            ds_n      <= 1'b1;
            we_n      <= 1'b1;
            data_oe_o <= 1'b0;
        end else begin
            as_n <= !(state == EBM_S0 || state == EBM_S2 ||
                      state == EBM_WAIT || state == EBM_FAST);
            ds_n <= !((state == EBM_S0 && !is_write) ||
                      (state == EBM_FAST && !is_write) ||
                      ((state == EBM_S2 || state == EBM_WAIT) &&
                       !is_fast));
            we_n <= !(is_write && state != EBM_IDLE && state != EBM_S4);
            data_oe_o <= is_write && state != EBM_IDLE &&
                         !(state == EBM_S4 && next_state == EBM_IDLE &&
                           1'b0);
        end
    end

    assign addr_strobe_b_o         = as_n;
    assign data_strobe_b_o         = ds_n;
    assign upper_byte_write_en_b_o = !(!we_n && lanes[1]);
    assign lower_byte_write_en_b_o = !(!we_n && lanes[0]);

    // Termination capture: acknowledge code, bus error and halt
    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_cap   <= ACK_NONE;
            bus_error_in_seen <= 1'b0;
            halt_seen <= 1'b0;
        end else if (accept) begin
            ack_cap   <= ACK_NONE;
            bus_error_in_seen <= 1'b0;
            halt_seen <= 1'b0;
        end else if (state == EBM_S2 || state == EBM_WAIT) begin
            if (terminated) begin
                ack_cap   <= ack_s;
                bus_error_in_seen <= bus_error_in_now;
                halt_seen <= halt_now;
            end
        end else if (state == EBM_S4) begin
            // Late bus error one clock after acknowledge still counts
            bus_error_in_seen <= bus_error_in_seen | bus_error_in_now;
            halt_seen <= halt_seen | (bus_error_in_now & halt_now);
        end
    end

    // Read data latched at the S4 (or EBM_FAST) falling edge, one after recognition
    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            rd_lat <= '0;
        else if ((state == EBM_S4 || state == EBM_FAST) && !is_write)
            rd_lat <= data_i;
    end

    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            rd_phase <= 1'b0;
        else
            rd_phase <= (state == EBM_S4 || state == EBM_FAST);
    end

    // Completion report to the core, one clock after the bus cycle ends
    always_ff @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o   <= 1'b0;
            rdata_o  <= '0;
            port8_o  <= 1'b0;
            status_o <= EBM_OK;
        end else begin
            done_o <= rd_phase;
            if (rd_phase) begin
                rdata_o <= rd_lat;
                port8_o <= !is_fast && ack_cap == ACK_PORT8;
                if (bus_error_in_seen && halt_seen)
                    status_o <= EBM_RETRY;
                else if (bus_error_in_seen)
                    status_o <= EBM_BUS_ERROR_IN;
                else
                    status_o <= EBM_OK;
            end
        end
    end

    // Assertions
    a_min_three_clk: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S0 && !is_fast |=> state != EBM_IDLE ##1
        state != EBM_IDLE)
        else $error("Acknowledged cycle shorter than three clocks");
    a_fast_two_clk: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S0 && is_fast |=> state == EBM_FAST ##1
        state == EBM_IDLE)
        else $error("Fast cycle not two clocks");
    a_zero_wait: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S2 && ack_seen |=> state == EBM_S4)
        else $error("Acknowledge at S2 did not skip waits");
    a_wait_insert: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S2 && !terminated |=> state == EBM_WAIT)
        else $error("Missing wait state");
    a_fast_no_ds: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i)
        is_fast && is_write && state != EBM_IDLE |=> ds_n)
        else $error("Data strobe asserted in fast write");
    a_attr_hold: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S4 |=> $stable(addr_o) && $stable(read_write_o))
        else $error("Attributes changed in S5");
    a_rw_level: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        accept |=> read_write_o == !is_write)
        else $error("Direction wrong in S0");
    a_strobe_s5: assert property (@(posedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S4 |=> as_n && ds_n)
        else $error("Strobes not negated in S5");
    a_done_pulse: assert property (@(negedge core_clk_i)
        disable iff (!rst_b_i)
        state == EBM_S4 |=> ##1 done_o)
        else $error("Done missing after S4");
    c_zero_wait_rd: cover property (@(negedge core_clk_i)
        state == EBM_S2 && ack_seen && !is_write);
    c_wait_wr: cover property (@(negedge core_clk_i)
        state == EBM_WAIT && is_write);
    c_fast_rd: cover property (@(negedge core_clk_i)
        state == EBM_FAST && !is_write);
    c_bus_error_in: cover property (@(negedge core_clk_i)
        done_o && status_o == EBM_BUS_ERROR_IN);
endmodule

// ===== ebm_slave_model.sv
`timescale 1ns/100ps
// Memory slave timed to the bus clock, answers after wait_i clocks
module ebm_slave_model
    import ebm_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        addr_strobe_b_i,
    input  wire logic        read_write_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic [1:0]  ack_i,
    input  wire logic [1:0]  err_i,
    input  wire logic [15:0] rdata_i,
    output logic [15:0]      data_o,
    output logic [1:0]       ack_b_o,
    output logic             bus_error_b_o,
    output logic             halt_b_o
);
    int cnt;

    always @(negedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 0;
            ack_b_o <= ACK_NONE;
            bus_error_b_o <= 1'b1;
            halt_b_o <= 1'b1;
            data_o <= 16'h0000;
        end else if (addr_strobe_b_i) begin
            // Released data lines toggle so stale data never looks valid
            cnt <= 0;
            ack_b_o <= ACK_NONE;
            bus_error_b_o <= 1'b1;
            halt_b_o <= 1'b1;
            data_o <= ~data_o;
        end else begin
            cnt <= cnt + 1;
            if (cnt >= int'(wait_i)) begin
                ack_b_o <= ack_i;
                bus_error_b_o <= (err_i == 2'h0);
                halt_b_o <= (err_i != 2'h2);
                if (read_write_i) begin
                    data_o <= rdata_i;
                end
            end
        end
    end
endmodule

// ===== external_bus_cycle_master_bench.sv
`timescale 1ns/100ps
module external_bus_cycle_master_bench
    import ebm_pkg::*;
();
    logic        clk = 0, rst_b = 0, vld = 0, wr = 0, fast_term_enable = 0;
    logic [31:0] adr = 0, a_o;
    logic [1:0]  siz = SIZ_WORD, dly = 0, s_ack = ACK_PORT16, s_err = 0;
    logic [2:0]  fc = 3'h5, fc_o;
    logic [15:0] wd = 0, s_rd = 0, rdat, d_out, d_in, bus_wd;
    logic [3:0]  s_wait = 0;
    logic [1:0]  ack_b;
    logic        rdy, done, p8, as_b, ds_b, uwe_b, lwe_b, rw, tsh, tsl;
    logic        oe, bus_error_in_b, halt_b, saw_ds, saw_uwe, saw_lwe, at_bad;
    ebm_status_e st;
    int          fails = 0, samples_checked = 0, lat, lat0;

    always #10 clk = ~clk;

    ebm_master u_ebm_master (.core_clk_i(clk), .rst_b_i(rst_b),
        .req_valid_i(vld), .req_ready_o(rdy), .req_write_i(wr),
        .req_addr_i(adr), .req_size_i(siz), .req_fc_i(fc),
        .req_wdata_i(wd), .fast_term_enable_i(fast_term_enable),
        .ack_delay_field_i(dly), .done_o(done), .rdata_o(rdat),
        .port8_o(p8), .status_o(st), .addr_o(a_o),
        .function_code_o(fc_o), .transfer_size_hi_o(tsh),
        .transfer_size_lo_o(tsl), .read_write_o(rw),
        .addr_strobe_b_o(as_b), .data_strobe_b_o(ds_b),
        .upper_byte_write_en_b_o(uwe_b), .lower_byte_write_en_b_o(lwe_b),
        .data_i(d_in), .data_o(d_out), .data_oe_o(oe),
        .port_ack_high_b_i(ack_b[1]), .port_ack_low_b_i(ack_b[0]),
        .bus_error_in_b_i(bus_error_in_b), .halt_b_i(halt_b),
        .bus_clock_out_o());

    ebm_slave_model u_ebm_slave_model (.core_clk_i(clk), .rst_b_i(rst_b),
        .addr_strobe_b_i(as_b), .read_write_i(rw), .wait_i(s_wait),
        .ack_i(s_ack), .err_i(s_err), .rdata_i(s_rd), .data_o(d_in),
        .ack_b_o(ack_b), .bus_error_b_o(bus_error_in_b), .halt_b_o(halt_b));

    // Bus attributes must stay put for as long as the strobe is low
    always @(posedge clk) begin
        if (as_b === 1'b0) begin
            if (ds_b === 1'b0) saw_ds = 1'b1;
            if (uwe_b === 1'b0) saw_uwe = 1'b1;
            if (lwe_b === 1'b0) saw_lwe = 1'b1;
            if ({rw, a_o, fc_o, tsh, tsl} !== {~wr, adr, fc, siz})
                at_bad = 1'b1;
            if (oe === 1'b1) bus_wd = d_out;
        end
    end

    task automatic chk(input string nm, input logic [39:0] seen,
                       input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic run(input logic w, input logic [31:0] a,
                       input logic [1:0] sz, input logic f);
        @(negedge clk);
        wr <= w; adr <= a; siz <= sz; fast_term_enable <= f; vld <= 1'b1;
        saw_ds = 0; saw_uwe = 0; saw_lwe = 0; at_bad = 0; bus_wd = 0;
        @(negedge clk);
        vld <= 1'b0;
        lat = 0;
        while (lat < 40 && done !== 1'b1) begin
            @(negedge clk);
            #1 lat++;
        end
        chk("done", done, 1);
    endtask

    task automatic t_read();
        s_wait = 0; s_ack = ACK_PORT16; s_err = 0; s_rd = 16'ha55a;
        run(0, 32'h0000_1000, SIZ_WORD, 0);
        lat0 = lat;
        chk("rdata", rdat, 16'ha55a);
        chk("port8", p8, 0);
        chk("status", st, EBM_OK);
        chk("attr", at_bad, 0);
        chk("ds", saw_ds, 1);
        chk("min_lat", lat0 >= 3, 1);
        chk("hold", {as_b, ds_b, a_o}, {2'h3, 32'h0000_1000});
        for (int n = 1; n < 4; n++) begin
            s_wait = 4'(n); s_rd = 16'h3c3c ^ 16'(n);
            run(0, 32'h0000_2002, SIZ_LONG, 0);
            chk("wait_lat", lat, lat0 + n);
            chk("wait_rd", rdat, 16'h3c3c ^ 16'(n));
        end
        $display("read test done");
    endtask

    task automatic t_port8_err();
        s_wait = 0; s_ack = ACK_PORT8; s_rd = 16'h5a00;
        run(0, 32'h0000_3001, SIZ_BYTE, 0);
        chk("port8", p8, 1);
        s_ack = ACK_PORT16;
        for (int e = 1; e < 3; e++) begin
            s_err = 2'(e);
            run(0, 32'h0000_3004, SIZ_WORD, 0);
            chk("err", st, (e == 1) ? EBM_BUS_ERROR_IN : EBM_RETRY);
        end
        s_err = 0;
        $display("port size and error test done");
    endtask

    task automatic t_write();
        wd = 16'h1234;
        run(1, 32'h0000_4000, SIZ_WORD, 0);
        chk("attr", at_bad, 0);
        chk("we", {saw_uwe, saw_lwe}, 2'h3);
        chk("wdata", bus_wd, 16'h1234);
        chk("ds", saw_ds, 1);
        chk("lat", lat, lat0);
        for (int b = 0; b < 2; b++) begin
            run(1, 32'h0000_4010 + b, SIZ_BYTE, 0);
            chk("byte_we", {saw_uwe, saw_lwe}, b ? 2'h1 : 2'h2);
        end
        $display("write test done");
    endtask

    task automatic t_fast();
        // No acknowledge at all: the cycle must end on its own
        s_ack = ACK_NONE; dly = 2'h3; s_rd = 16'hbeef;
        run(0, 32'h0000_5000, SIZ_WORD, 1);
        chk("fast_lat", lat < lat0, 1);
        chk("fast_rd", rdat, 16'hbeef);
        chk("fast_ds_rd", saw_ds, 1);
        run(1, 32'h0000_5002, SIZ_WORD, 1);
        chk("fast_wlat", lat < lat0, 1);
        chk("fast_ds_wr", saw_ds, 0);
        s_ack = ACK_PORT16; dly = 0;
        $display("fast termination test done");
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        fails++;
        end_sim();
    end

    initial begin
        // Release away from both clock edges so no flop races the reset
        repeat (4) @(negedge clk);
        #5 rst_b = 1'b1;
        t_read();
        t_port8_err();
        t_write();
        t_fast();
        end_sim();
    end
endmodule
